// *** rtl/tmbs_pkg.sv ***
// Shared constants and types for the test-mode and boundary-scan block.
package tmbs_pkg;
  localparam logic [1:0] TMBS_SEL_NORMAL = 2'h0;
  localparam logic [1:0] TMBS_SEL_NAND = 2'h3;
  localparam logic [1:0] TMBS_SEL_RESET_VAL = 2'h0;
  localparam int TMBS_SYNC_STAGES = 3;
  localparam int TMBS_NAND_WIDTH = 8;
  localparam int TMBS_BSR_WIDTH = 8;
  localparam int TMBS_IR_WIDTH = 2;
  localparam logic [1:0] TMBS_IR_EXTEST = 2'h0;
  localparam logic [1:0] TMBS_IR_SAMPLE = 2'h1;
  localparam logic [1:0] TMBS_IR_BYPASS = 2'h3;
  localparam logic [1:0] TMBS_IR_CAPTURE = 2'h1;
  localparam logic [1:0] TMBS_IR_RESET_VAL = 2'h3;
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
    TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
    TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
  } tmbs_tap_type;
endpackage

// *** rtl/tmbs_top.sv ***
// Test-mode strap capture, NAND tree and TAP controller.
`timescale 1ns/1ns
// What this block does
// R1 - In NAND-tree mode every pin output enable drops; the serial clock and TDO enables are not gated.
// R2 - In NAND-tree mode the serial clock pin carries the NAND tree result.
// R3 - The two-bit test select strap is captured during reset and sets mode.
// R4 - The mode holds until the strap changed and a new reset event occurred.
// R5 - Code 00 is normal, code 11 is NAND tree, codes 01 and 10 are reserved.
// R6 - The board holds both strap inputs low for normal operation.
// R7 - A standard boundary-scan test access port is provided and used.
// R8 - The port uses TCK, TDI, TDO, TMS and active-low TRST only.
// R9 - An undriven TMS reads high so the TAP stays in reset.
// R10 - PCI reset low, local reset low or backend health high is a reset.
// R11 - The strap is sampled during reset, frozen at release, reserved is off.
// R12 - Five TCK rises with TMS high, or TRST low, reset the TAP.
module tmbs_top
  import tmbs_pkg::*;
(
  input wire logic mclk, // System clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic pciResetN, // PCI reset input, active low.
  input wire logic local_bus_reset_in_n, // Local bus reset, active low.
  input wire logic backend_ok_n, // Backend health, high means reset.
  input wire logic [1:0] test_select_strap, // Test mode strap pins.
  input wire logic [TMBS_NAND_WIDTH-1:0] nandIn, // NAND tree input pins.
  input wire logic [TMBS_BSR_WIDTH-1:0] pinIn, // Pin levels for capture.
  input wire logic [TMBS_BSR_WIDTH-1:0] coreOut, // Core pin outputs.
  input wire logic [TMBS_BSR_WIDTH-1:0] coreOe, // Core pin enables.
  input wire logic sclCore, // Core serial clock level.
  input wire logic tck, // Test clock.
  input wire logic tdi, // Test data in.
  input wire logic tmsIn, // Test mode select pin level.
  input wire logic tmsDriven, // Tester drives TMS when high.
  input wire logic trstN, // Test reset, active low.
  output logic [TMBS_BSR_WIDTH-1:0] pinOut, // Pin output values.
  output logic [TMBS_BSR_WIDTH-1:0] pinOe, // Pin output enables.
  output logic sclOut, // Serial clock pin value.
  output logic sclOe, // Serial clock pin enable.
  output logic tdo, // Test data out value.
  output logic tdoOe, // Test data out enable.
  output logic nandMode, // NAND tree mode active.
  output logic tapInReset // TAP in Test-Logic-Reset.
);
  //////////////////////////////////////////////////////////////////////////
  logic [1:0] modeSel_r;
  logic [TMBS_SYNC_STAGES-1:0] tckSync_r, tmsSync_r, tdiSync_r, trstSync_r;
  logic [TMBS_NAND_WIDTH-1:0] nandSync1_r, nandSync2_r;
  logic tckQual_r;
  tmbs_tap_type tap_r, tap_nxt;
  logic [TMBS_IR_WIDTH-1:0] irShift_r, ir_r;
  logic [TMBS_BSR_WIDTH-1:0] bsrShift_r, bsrUpd_r;
  logic bypass_r;
  wire chipReset = !pciResetN || !local_bus_reset_in_n
    || backend_ok_n; // see R10
  wire anyReset = !nrst || chipReset;

  // Strap is transparent while reset is held and freezes when it ends.
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      modeSel_r <= TMBS_SEL_RESET_VAL;
    else if (chipReset)
      modeSel_r <= test_select_strap; // see R3 see R4 see R11
  wire nandSel = (modeSel_r == TMBS_SEL_NAND); // see R5 see R11

  //////////////////////////////////////////////////////////////////////////
  // Test port inputs cross in through three stages; edges need stages 2 and 3.
  wire tmsPin = tmsDriven ? tmsIn : 1'b1; // see R9
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      tckSync_r <= '0;
      tmsSync_r <= '1;
      tdiSync_r <= '0;
      trstSync_r <= '0;
      tckQual_r <= 1'b0;
    end
    else
    begin
      tckSync_r <= {tckSync_r[1:0], tck};
      tmsSync_r <= {tmsSync_r[1:0], tmsPin};
      tdiSync_r <= {tdiSync_r[1:0], tdi};
      trstSync_r <= {trstSync_r[1:0], trstN};
      if (tckSync_r[1] == tckSync_r[2])
        tckQual_r <= tckSync_r[2];
    end
  wire tckAgree = (tckSync_r[1] == tckSync_r[2]);
  wire tckRise = tckAgree && tckSync_r[2] && !tckQual_r;
  wire tckFall = tckAgree && !tckSync_r[2] && tckQual_r;
  wire tmsS = tmsSync_r[2];
  wire tdiS = tdiSync_r[2];
  wire trstLow = !trstSync_r[1] || !trstSync_r[2]; // see R12
  wire tapRst = anyReset || !trstN;

  //////////////////////////////////////////////////////////////////////////
  // Standard TAP state machine; TMS high walks to reset in five edges.
  always_comb
  begin
    tap_nxt = tap_r;
    case (tap_r)
      TAP_RESET: tap_nxt = tmsS ? TAP_RESET : TAP_IDLE; // see R12
      TAP_IDLE: tap_nxt = tmsS ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_nxt = tmsS ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_nxt = tmsS ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: tap_nxt = tmsS ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_nxt = tmsS ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: tap_nxt = tmsS ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: tap_nxt = tmsS ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_nxt = tmsS ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_nxt = tmsS ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tap_nxt = tmsS ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: tap_nxt = tmsS ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_nxt = tmsS ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: tap_nxt = tmsS ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: tap_nxt = tmsS ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_nxt = tmsS ? TAP_SEL_DR : TAP_IDLE;
      default: tap_nxt = TAP_RESET;
    endcase
  end

  // TRST also resets asynchronously; the synchronised copy covers release.
  always_ff @(posedge mclk or posedge tapRst)
    if (tapRst)
      tap_r <= TAP_RESET; // see R7 see R8 see R12
    else if (trstLow)
      tap_r <= TAP_RESET; // see R12
    else if (tckRise)
      tap_r <= tap_nxt;

  //////////////////////////////////////////////////////////////////////////
  // Instruction, bypass and boundary registers shift on TCK rise.
  wire selExtest = (ir_r == TMBS_IR_EXTEST);
  wire selBsr = selExtest || (ir_r == TMBS_IR_SAMPLE);
  always_ff @(posedge mclk or posedge tapRst)
    if (tapRst)
    begin
      irShift_r <= '0;
      ir_r <= TMBS_IR_RESET_VAL;
      bsrShift_r <= '0;
      bsrUpd_r <= '0;
      bypass_r <= 1'b0;
    end
    else if (trstLow || tap_r == TAP_RESET)
      ir_r <= TMBS_IR_RESET_VAL;
    else if (tckRise)
    begin
      case (tap_r)
        TAP_CAP_IR: irShift_r <= TMBS_IR_CAPTURE;
        TAP_SH_IR: irShift_r <= {tdiS, irShift_r[TMBS_IR_WIDTH-1:1]};
        TAP_CAP_DR:
        begin
          bypass_r <= 1'b0;
          bsrShift_r <= pinIn;
        end
        TAP_SH_DR:
        begin
          bypass_r <= tdiS;
          bsrShift_r <= {tdiS, bsrShift_r[TMBS_BSR_WIDTH-1:1]};
        end
        default: ;
      endcase
    end
    else if (tckFall && tap_r == TAP_UPD_IR)
      ir_r <= irShift_r;
    else if (tckFall && tap_r == TAP_UPD_DR && selBsr)
      bsrUpd_r <= bsrShift_r;

  // TDO changes on the falling edge and floats outside shift states.
  wire shifting = (tap_r == TAP_SH_DR) || (tap_r == TAP_SH_IR);
  wire tdoBit = (tap_r == TAP_SH_IR) ? irShift_r[0] :
                selBsr ? bsrShift_r[0] : bypass_r;
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      tdo <= 1'b0;
      tdoOe <= 1'b0;
      tapInReset <= 1'b1;
    end
    else
    begin
      if (tckFall)
      begin
        tdo <= tdoBit;
        tdoOe <= shifting;
      end
      tapInReset <= (tap_r == TAP_RESET);
    end

  //////////////////////////////////////////////////////////////////////////
  // NAND tree chains all eight nandIn pins; result goes out on the serial clock.
  logic [TMBS_NAND_WIDTH:0] chain;
  assign chain[0] = 1'b1;
  genvar gi;
  generate
    for (gi = 0; gi < TMBS_NAND_WIDTH; gi++)
    begin : g_nand
      assign chain[gi+1] = ~(chain[gi] & nandSync2_r[gi]);
    end
  endgenerate

  wire [TMBS_BSR_WIDTH-1:0] outVal = selExtest ? bsrUpd_r : coreOut;
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      nandSync1_r <= '0;
      nandSync2_r <= '0;
      pinOut <= '0;
      pinOe <= '0;
      sclOut <= 1'b0;
      sclOe <= 1'b0;
      nandMode <= 1'b0;
    end
    else
    begin
      nandSync1_r <= nandIn;
      nandSync2_r <= nandSync1_r;
      nandMode <= nandSel;
      pinOut <= outVal;
      pinOe <= nandSel ? '0 : (selExtest ? '1 : coreOe); // see R1
      sclOut <= nandSel ? chain[TMBS_NAND_WIDTH] : sclCore; // see R2
      sclOe <= 1'b1; // see R1
    end
endmodule // tmbs_top

// *** verif/tmbs_top_props.sv ***
// Port assertions for the test-mode and boundary-scan block.
`timescale 1ns/1ns
module tmbs_top_props
  import tmbs_pkg::*;
(
  input wire logic mclk, // Clock.
  input wire logic nrst, // Reset.
  input wire logic pciResetN, // In.
  input wire logic local_bus_reset_in_n, // In.
  input wire logic backend_ok_n, // In.
  input wire logic [1:0] test_select_strap, // In.
  input wire logic [TMBS_NAND_WIDTH-1:0] nandIn, // In.
  input wire logic sclCore, // In.
  input wire logic tmsDriven, // In.
  input wire logic trstN, // In.
  input wire logic [TMBS_BSR_WIDTH-1:0] pinOe, // Out.
  input wire logic sclOut, // Out.
  input wire logic sclOe, // Out.
  input wire logic nandMode, // Out.
  input wire logic tapInReset // Out.
);
  logic chipRst;
  logic nandRes;
  assign chipRst = !pciResetN || !local_bus_reset_in_n || backend_ok_n;
  always_comb
  begin
    nandRes = 1'b1;
    for (int i = 0; i < TMBS_NAND_WIDTH; i++)
      nandRes = ~(nandRes & nandIn[i]);
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence capNand;
    (chipRst && test_select_strap == TMBS_SEL_NAND)[*2];
  endsequence
  sequence capOther;
    (chipRst && test_select_strap != TMBS_SEL_NAND)[*2];
  endsequence
  pins_float_a: assert property (nandMode |-> pinOe == '0)
    else $error("pin enabled in nand mode");
  scl_enabled_a: assert property ($past(nrst) |-> sclOe)
    else $error("serial clock enable low");
  nand_result_a: assert property ((nandMode && $stable(nandIn))[*4]
    |-> sclOut == nandRes) else $error("wrong nand tree result");
  scl_pass_a: assert property ((!nandMode && $stable(sclCore))[*3]
    |-> sclOut == sclCore) else $error("serial clock not passed");
  mode_hold_a: assert property ((!chipRst)[*3] |-> $stable(nandMode))
    else $error("mode changed without reset");
  nand_load_a: assert property (capNand |=> nandMode)
    else $error("nand code not taken");
  rsv_off_a: assert property (capOther |=> !nandMode)
    else $error("nand mode on other code");
  trst_reset_a: assert property ((!trstN)[*6] |-> tapInReset)
    else $error("tap not reset by test reset");
  tms_pull_a: assert property ((!tmsDriven)[*5] ##0 tapInReset
    |=> tapInReset) else $error("tap left reset with tms floating");
endmodule // tmbs_top_props

// *** verif/tmbs_jtag_tester.sv ***
// Board tester model driving the test access port pins.
`timescale 1ns/1ns
module tmbs_jtag_tester (
  output logic tck, // Test clock.
  output logic tdi, // Test data.
  output logic tmsIn, // Mode select level.
  output logic tmsDriven, // Mode select driven.
  output logic trstN, // Test reset.
  input wire logic [2:0] want // Wanted reset, drive, tms.
);
  initial
  begin
    tck = 1'b0;
    tdi = 1'b0;
    tmsIn = 1'b1;
    tmsDriven = 1'b1;
    trstN = 1'b0;
  end
  always #80 tck = ~tck;
  // Pins move on the falling edge so the rising edge samples them settled.
  always @(negedge tck)
  begin
    trstN <= want[2];
    tmsDriven <= want[1];
    tmsIn <= want[1] ? want[0] : ~tmsIn;
    tdi <= ~tdi;
  end
endmodule // tmbs_jtag_tester

// *** verif/tmbs_top_tb_top.sv ***
// Self-checking bench for the test-mode and boundary-scan block.
`timescale 1ns/1ns
`define CHK(a, e) check_count++; if ((a) !== (e)) begin \
  $display("CHECK FAILED %0t %h %h", $time, a, e); err_total++; end
module tmbs_top_tb_top;
  import tmbs_pkg::*;
  logic mclk, nrst, sclCore, tck, tdi, tmsIn, tmsDriven, trstN;
  logic [2:0] rstIn, want;
  logic [1:0] test_select_strap;
  logic [7:0] nandIn, pinOe, pinOut;
  logic sclOut, sclOe, nandMode, tapInReset, tdo, tdoOe;
  int err_total, check_count, cyc;
  tmbs_jtag_tester tmbs_jtag_tester_inst (.tck, .tdi, .tmsIn, .tmsDriven,
    .trstN, .want);
  tmbs_top tmbs_top_inst (.mclk, .nrst, .pciResetN(rstIn[0]),
    .local_bus_reset_in_n(rstIn[1]), .backend_ok_n(rstIn[2]),
    .test_select_strap, .nandIn, .pinIn(8'h00), .coreOut(8'h3C),
    .coreOe(8'h5A), .sclCore, .tck, .tdi, .tmsIn, .tmsDriven, .trstN,
    .pinOut, .pinOe, .sclOut, .sclOe, .tdo, .tdoOe, .nandMode,
    .tapInReset);
  function automatic logic nandRef(input logic [7:0] v);
    logic c;
    c = 1'b1;
    for (int i = 0; i < 8; i++)
      c = ~(c & v[i]);
    return c;
  endfunction
  task chipReset(input int k, input logic [1:0] s);
    test_select_strap <= s;
    rstIn <= 3'h3 ^ (3'h1 << k);
    repeat (4) @(posedge mclk);
    rstIn <= 3'h3;
    repeat (4) @(posedge mclk);
  endtask
  task waitTap(input logic v);
    int n;
    n = 0;
    while (tapInReset !== v && n < 300)
    begin
      @(posedge mclk);
      n++;
    end
  endtask
  // Called just after a TCK rise; the tester applies want at the next fall.
  task walk(input logic [2:0] w, input int n);
    @(posedge mclk);
    want <= w;
    repeat (n) @(posedge tck);
  endtask
  task testModes();
    chipReset(0, 2'h0);
    `CHK(pinOe, 8'h5A)
    `CHK(pinOut, 8'h3C)
    sclCore <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK(sclOut, 1'b1)
    chipReset(1, 2'h3);
    `CHK(pinOe, 8'h00)
    `CHK(sclOe, 1'b1)
    for (int v = 0; v < 256; v += 85)
    begin
      nandIn <= v[7:0];
      repeat (5) @(posedge mclk);
      `CHK(sclOut, nandRef(v[7:0]))
    end
    test_select_strap <= 2'h0;
    repeat (8) @(posedge mclk);
    `CHK(nandMode, 1'b1)
    chipReset(0, 2'h1);
    `CHK(nandMode, 1'b0)
    chipReset(1, 2'h3);
    chipReset(2, 2'h2);
    `CHK(nandMode, 1'b0)
    $display("mode test done");
  endtask
  task testTap();
    want <= 3'h6;
    waitTap(1'b0);
    `CHK(tapInReset, 1'b0)
    // Into shift-DR, then four TMS-high edges stop one short of reset.
    walk(3'h7, 1);
    walk(3'h6, 3);
    repeat (10) @(posedge mclk);
    `CHK(tdoOe, 1'b1)
    `CHK(tdo, 1'b0)
    walk(3'h7, 4);
    repeat (10) @(posedge mclk);
    `CHK(tapInReset, 1'b0)
    `CHK(tdoOe, 1'b0)
    walk(3'h7, 1);
    repeat (10) @(posedge mclk);
    `CHK(tapInReset, 1'b1)
    want <= 3'h6;
    waitTap(1'b0);
    want <= 3'h4;
    waitTap(1'b1);
    `CHK(tapInReset, 1'b1)
    want <= 3'h6;
    waitTap(1'b0);
    want <= 3'h2;
    waitTap(1'b1);
    `CHK(tapInReset, 1'b1)
    $display("tap test done");
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always #2 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      give_verdict();
    end
  end
  initial
  begin
    mclk = 1'b0;
    nrst = 1'b0;
    rstIn = 3'h3;
    want = 3'h3;
    test_select_strap = 2'h0;
    nandIn = 8'h00;
    sclCore = 1'b0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    testModes();
    testTap();
    give_verdict();
  end
endmodule // tmbs_top_tb_top
bind tmbs_top tmbs_top_props tmbs_top_props_inst (.mclk, .nrst, .pciResetN,
  .local_bus_reset_in_n, .backend_ok_n, .test_select_strap, .nandIn,
  .sclCore, .tmsDriven, .trstN, .pinOe, .sclOut, .sclOe, .nandMode,
  .tapInReset);
